// *** logic/sia_pkg.sv ***
// Constants shared by the SCSI target bus adapter.
package sia_pkg;
    // Clock and timing.
    localparam int          CLK_PERIOD_NS     = 5;
    localparam int          SYNC_DEPTH        = 2;
    localparam int          BUS_FREE_MIN_CYC  = 3;
    localparam int          BUS_FREE_MAX_CYC  = 4;
    // Counted after the synchroniser, so its latency is taken off the bus free wait.
    localparam int          FREE_WAIT_CYC     = BUS_FREE_MIN_CYC - SYNC_DEPTH;
    localparam int          DATA_SETUP_NS     = 55;
    localparam int          DATA_SETUP_CYC    = (DATA_SETUP_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
    localparam int          SETUP_CNT_W       = 9;

    // Register byte addresses.
    localparam logic [3:0]  ADDR_CTRL         = 4'h0;
    localparam logic [3:0]  ADDR_STATUS       = 4'h4;

    // Control register fields.
    localparam int          CTRL_EXTRA_LSB    = 0;
    localparam int          CTRL_EXTRA_W      = 8;
    localparam logic [7:0]  CTRL_RESET        = 8'h00;

    // Status register fields.
    localparam int          STAT_PAR_ERR      = 0;
    localparam int          STAT_BUS_BUSY     = 1;
    localparam int          STAT_BUSY_SENSE   = 2;
    localparam int          STAT_XFER_ACTIVE  = 3;
    localparam int          STAT_STATE_LSB    = 4;
    localparam int          STAT_BYTE_LSB     = 8;

    localparam logic [31:0] READ_ZERO         = 32'h0000_0000;
    localparam logic [7:0]  BYTE_ZERO         = 8'h00;

    // Handshake states.
    typedef enum logic [1:0] {
        SIA_IDLE  = 2'b00,
        SIA_SETUP = 2'b01,
        SIA_REQ   = 2'b10,
        SIA_DONE  = 2'b11
    } sia_state_t;
endpackage

// *** logic/sia_target_adapter.sv ***
// SCSI target bus adapter: parity, arbitration lines, REQ/ACK handshake and data latches.
//
// Operation
// RULE_01: Parity-mode high: check bus parity, raise error output on a parity error.
// RULE_02: Parity-mode low: pass each byte's bus parity bit to the buffer side.
// RULE_03: In checking mode a parity error stays latched until cleared.
// RULE_04: Driving parity-mode low clears the latched error before recovery.
// RULE_05: Odd parity over eight data bits, for generation and for checking.
// RULE_06: Always generate bus parity when driving data and during selection.
// RULE_07: A controller without parity keeps parity-mode high and ignores the output.
// RULE_08: The bus is occupied while select or busy is asserted.
// RULE_09: Bus free delay is between three and four clock periods.
// RULE_10: The system supplies a clock between 2.5 and 5 MHz; the timing constants and bench assume a 5 ns (200 MHz) period.
// RULE_11: Target enable low disables every bus driver except busy.
// RULE_12: Drive select only when the select-drive input asks for it.
// RULE_13: Reflect the bus select line onto the select-sense output.
// RULE_14: Drive busy only when the busy-drive input asks for it.
// RULE_15: Reflect bus busy onto the busy-sense output.
// RULE_16: Drive message, command/data and direction lines from the phase inputs.
// RULE_17: The latch-out strobe captures buffer data into the internal latches.
// RULE_18: The bus-out gate drives latched data onto the bus data lines.
// RULE_19: The bus-in gate drives bus data onto the buffer data lines.
// RULE_20: A rising buffer-port request asserts REQ, starting a byte transfer.
// RULE_21: ACK asserted: release REQ and raise the buffer-port acknowledge.
// RULE_22: When sending, bus data is valid at least 55 ns before REQ.
// RULE_23: All logic runs on one clock; bus inputs are synchronised first.
`timescale 1ns/1ps
module sia_target_adapter
    import sia_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Avalon-MM register slave.
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // SCSI bus, wire levels; a line is asserted when low.
    input  wire logic [7:0]  scsi_db_in,
    output logic      [7:0]  scsi_db_out,
    output logic      [7:0]  scsi_db_oe,
    input  wire logic        scsi_dbp_in,
    output logic             scsi_dbp_out,
    output logic             scsi_dbp_oe,
    input  wire logic        scsi_sel_in,
    output logic             scsi_sel_out,
    output logic             scsi_sel_oe,
    input  wire logic        scsi_busy_sense,
    output logic             scsi_busy_drive_req,
    output logic             scsi_bsy_oe,
    input  wire logic        scsi_ack_n,
    output logic             scsi_req_oe,
    output logic             scsi_msg_oe,
    output logic             scsi_cd_oe,
    output logic             scsi_io_oe,
    // Buffer controller side, active high.
    input  wire logic [7:0]  buffer_data_bus_in,
    output logic      [7:0]  buffer_data_bus_out,
    output logic             buffer_data_bus_oe,
    input  wire logic        latch_out_strobe,
    input  wire logic        bus_out_gate,
    input  wire logic        bus_in_gate,
    input  wire logic        port_b_req,
    output logic             port_b_ack,
    input  wire logic        parity_mode_clear,
    output logic             parity_or_error_out,
    input  wire logic        target_drive_enable,
    input  wire logic        busy_drive_req,
    output logic             busy_sense,
    input  wire logic        sel_drive_req,
    output logic             sel_sense,
    input  wire logic        msg_phase_in,
    input  wire logic        cd_phase_in,
    input  wire logic        io_phase_in
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers; only the second stage is used by the logic.

    logic [11:0] sync_q1;
    logic [11:0] sync_q2;
    wire  [11:0] sync_raw = {scsi_ack_n, scsi_busy_sense, scsi_sel_in, scsi_dbp_in, scsi_db_in};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_q1 <= 12'hFFF;
            sync_q2 <= 12'hFFF;
        end else begin
            sync_q1 <= sync_raw; // RULE_23
            sync_q2 <= sync_q1;
        end
    end

    wire [7:0] bus_data   = ~sync_q2[7:0];
    wire       bus_parity = ~sync_q2[8];
    wire       sel_s      = ~sync_q2[9];
    wire       bsy_s      = ~sync_q2[10];
    wire       ack_s      = ~sync_q2[11];
    wire       bus_busy_s = sel_s | bsy_s; // RULE_08

    ////////////////////////////////////////////////////////////////////////////
    // Register slave.

    logic [7:0]  ctrl;
    logic        par_err;
    logic        preq_q;
    logic [7:0]  in_latch;
    logic [7:0]  out_latch;
    logic [SETUP_CNT_W-1:0] setup_cnt;
    sia_state_t  state;
    sia_state_t  next_state;

    wire        bus_access = (avs_read | avs_write) & avs_waitrequest;
    wire        wr_take    = avs_write & ~avs_waitrequest;
    wire        hit_ctrl   = avs_address == ADDR_CTRL;
    wire        hit_status = avs_address == ADDR_STATUS;
    wire [31:0] status_word = {16'h0000, in_latch, 2'b00, state, state != SIA_IDLE,
                               busy_sense, bus_busy_s, par_err};
    wire [31:0] read_word  = hit_ctrl   ? {24'h00_0000, ctrl} :
                             hit_status ? status_word : READ_ZERO;

    // One wait cycle, then waitrequest drops for the single accepting edge.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= READ_ZERO;
            ctrl            <= CTRL_RESET;
        end else begin
            avs_waitrequest <= ~bus_access;
            if (bus_access) begin
                avs_readdata <= avs_read ? read_word : READ_ZERO;
            end
            if (wr_take && hit_ctrl && avs_byteenable[0]) begin
                ctrl <= avs_writedata[CTRL_EXTRA_LSB +: CTRL_EXTRA_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration lines and bus free delay.

    // The count restarts whenever either line is seen busy, so a short release rearms it.
    logic [1:0] free_cnt;
    wire        free_done = free_cnt >= 2'(FREE_WAIT_CYC);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            free_cnt   <= 2'd0;
            busy_sense <= 1'b1;
            sel_sense  <= 1'b0;
        end else begin
            free_cnt   <= bus_busy_s ? 2'd0 : (free_done ? free_cnt : free_cnt + 2'd1);
            busy_sense <= bus_busy_s | ~free_done; // RULE_09 RULE_15
            sel_sense  <= sel_s; // RULE_13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data latches, drivers and parity.

    // Received data shares the ACK synchroniser depth, so it is settled when ACK is seen.
    wire drive_data = bus_out_gate & target_drive_enable;
    wire drive_sel  = sel_drive_req & target_drive_enable;
    wire odd_par    = ~^out_latch;
    wire rx_capture = state == SIA_REQ && ack_s && !io_phase_in;
    wire par_bad    = ~^{bus_data, bus_parity};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_latch           <= BYTE_ZERO;
            in_latch            <= BYTE_ZERO;
            scsi_db_out         <= 8'hFF;
            scsi_db_oe          <= BYTE_ZERO;
            scsi_dbp_out        <= 1'b1;
            scsi_dbp_oe         <= 1'b0;
            scsi_sel_out        <= 1'b0;
            scsi_sel_oe         <= 1'b0;
            scsi_busy_drive_req        <= 1'b0;
            scsi_bsy_oe         <= 1'b0;
            scsi_msg_oe         <= 1'b0;
            scsi_cd_oe          <= 1'b0;
            scsi_io_oe          <= 1'b0;
            buffer_data_bus_out <= BYTE_ZERO;
            buffer_data_bus_oe  <= 1'b0;
            par_err             <= 1'b0;
            parity_or_error_out <= 1'b0;
        end else begin
            if (latch_out_strobe) begin
                out_latch <= buffer_data_bus_in; // RULE_17
            end
            if (rx_capture) begin
                in_latch <= bus_data;
            end
            scsi_db_out  <= ~out_latch;
            scsi_db_oe   <= {8{drive_data}}; // RULE_18 RULE_11
            scsi_dbp_out <= ~odd_par; // RULE_05
            scsi_dbp_oe  <= drive_data | drive_sel; // RULE_06
            scsi_sel_oe  <= drive_sel; // RULE_12
            scsi_bsy_oe  <= busy_drive_req; // RULE_14
            scsi_msg_oe  <= msg_phase_in & target_drive_enable; // RULE_16
            scsi_cd_oe   <= cd_phase_in & target_drive_enable;
            scsi_io_oe   <= io_phase_in & target_drive_enable;
            buffer_data_bus_out <= rx_capture ? bus_data : in_latch;
            buffer_data_bus_oe  <= bus_in_gate; // RULE_19
            // The error is cleared only while checking is off, so a new event never races it.
            if (!parity_mode_clear) begin
                par_err <= 1'b0; // RULE_04
            end else if (rx_capture && par_bad) begin
                par_err <= 1'b1; // RULE_03
            end
            if (parity_mode_clear) begin
                parity_or_error_out <= par_err | (rx_capture & par_bad); // RULE_01
            end else begin
                parity_or_error_out <= bus_parity; // RULE_02
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // REQ/ACK handshake.

    wire req_rise  = port_b_req & ~preq_q;
    wire xfer_out  = io_phase_in;
    wire [SETUP_CNT_W-1:0] setup_need = SETUP_CNT_W'(DATA_SETUP_CYC) + {1'b0, ctrl};
    wire setup_met = setup_cnt >= setup_need;

    always_comb begin
        next_state = state;
        case (state)
            SIA_IDLE: begin
                if (req_rise) begin
                    next_state = xfer_out ? SIA_SETUP : SIA_REQ; // RULE_20
                end
            end
            SIA_SETUP: begin
                if (setup_met) begin
                    next_state = SIA_REQ; // RULE_22
                end
            end
            SIA_REQ: begin
                if (ack_s) begin
                    next_state = SIA_DONE; // RULE_21
                end
            end
            SIA_DONE: begin
                if (!port_b_req && !ack_s) begin
                    next_state = SIA_IDLE;
                end
            end
            default: next_state = SIA_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state       <= SIA_IDLE;
            preq_q      <= 1'b0;
            setup_cnt   <= '0;
            scsi_req_oe <= 1'b0;
            port_b_ack  <= 1'b0;
        end else begin
            state       <= next_state;
            preq_q      <= port_b_req;
            setup_cnt   <= (state == SIA_SETUP && scsi_db_oe[0] && !setup_met) ?
                           setup_cnt + 1'b1 : (state == SIA_SETUP ? setup_cnt : '0);
            scsi_req_oe <= next_state == SIA_REQ && target_drive_enable; // RULE_20 RULE_11
            port_b_ack  <= next_state == SIA_DONE; // RULE_21
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    sequence s_req_acked;
        scsi_req_oe && ack_s && state == SIA_REQ;
    endsequence

    sequence s_bus_released;
        bus_busy_s ##1 !bus_busy_s [*2];
    endsequence

    AST_ERR_RAISE: assert property (@(posedge clk) disable iff (!reset_n) // RULE_01
        parity_mode_clear && rx_capture && par_bad |=> parity_or_error_out)
        else $error("parity error not reported");
    AST_PASS_PARITY: assert property (@(posedge clk) disable iff (!reset_n) // RULE_02
        !parity_mode_clear |=> parity_or_error_out == $past(bus_parity))
        else $error("parity bit not passed through");
    AST_ERR_HOLD: assert property (@(posedge clk) disable iff (!reset_n) // RULE_03
        par_err && parity_mode_clear |=> par_err && parity_or_error_out)
        else $error("latched parity error lost");
    AST_ERR_CLEAR: assert property (@(posedge clk) disable iff (!reset_n) // RULE_04
        !parity_mode_clear |=> !par_err)
        else $error("parity error not cleared");
    AST_ERR_CLEAR_OUT: assert property (@(posedge clk) disable iff (!reset_n) // RULE_04
        !parity_mode_clear ##1 (parity_mode_clear && !(rx_capture && par_bad)) |=> !parity_or_error_out)
        else $error("error output not released after clear");
    AST_PAR_GEN: assert property (@(posedge clk) disable iff (!reset_n) // RULE_05
        scsi_db_oe[0] |-> ^{~scsi_db_out, ~scsi_dbp_out})
        else $error("driven bus parity not odd");
    AST_PAR_DRIVE: assert property (@(posedge clk) disable iff (!reset_n) // RULE_06
        $past(drive_data || drive_sel) |-> scsi_dbp_oe)
        else $error("parity not driven");
    AST_BUS_FREE: assert property (@(posedge clk) disable iff (!reset_n) // RULE_09
        s_bus_released |-> busy_sense ##1 !busy_sense)
        else $error("bus free delay wrong");
    AST_TEN_OFF: assert property (@(posedge clk) disable iff (!reset_n) // RULE_11
        !target_drive_enable |=> !scsi_req_oe && scsi_db_oe == BYTE_ZERO && !scsi_sel_oe
            && !scsi_dbp_oe && !scsi_msg_oe && !scsi_cd_oe && !scsi_io_oe)
        else $error("driver active with target disabled");
    AST_REQ_START: assert property (@(posedge clk) disable iff (!reset_n) // RULE_20
        state == SIA_IDLE && req_rise && !xfer_out && target_drive_enable |=> scsi_req_oe)
        else $error("request did not raise REQ");
    AST_ACK_DONE: assert property (@(posedge clk) disable iff (!reset_n) // RULE_21
        s_req_acked |=> !scsi_req_oe && port_b_ack)
        else $error("ACK did not complete transfer");
    AST_REQ_SETUP: assert property (@(posedge clk) disable iff (!reset_n) // RULE_22
        $rose(scsi_req_oe) && $past(state) == SIA_SETUP |-> $past(setup_cnt) >= DATA_SETUP_CYC)
        else $error("REQ before data setup time");

    // Pin level and output latch pass-through checks.
    AST_SEL_DRIVE: assert property (@(posedge clk) disable iff (!reset_n) // RULE_12
        !sel_drive_req |=> !scsi_sel_oe)
        else $error("select driven without request");
    AST_SEL_SENSE: assert property (@(posedge clk) disable iff (!reset_n) // RULE_13
        1'b1 |=> sel_sense == $past(sel_s))
        else $error("select sense does not follow bus");
    AST_BSY_DRIVE: assert property (@(posedge clk) disable iff (!reset_n) // RULE_14
        1'b1 |=> scsi_bsy_oe == $past(busy_drive_req))
        else $error("busy drive does not follow request");
    AST_BUSY_SENSE: assert property (@(posedge clk) disable iff (!reset_n) // RULE_15
        bus_busy_s |=> busy_sense)
        else $error("busy sense low while bus occupied");
    AST_PHASE: assert property (@(posedge clk) disable iff (!reset_n) // RULE_16
        target_drive_enable |=> {scsi_msg_oe, scsi_cd_oe, scsi_io_oe}
            == $past({msg_phase_in, cd_phase_in, io_phase_in}))
        else $error("phase lines do not follow inputs");
    AST_LATCH: assert property (@(posedge clk) disable iff (!reset_n) // RULE_17
        latch_out_strobe |=> out_latch == $past(buffer_data_bus_in))
        else $error("buffer byte not latched");
    AST_BUF_GATE: assert property (@(posedge clk) disable iff (!reset_n) // RULE_19
        1'b1 |=> buffer_data_bus_oe == $past(bus_in_gate))
        else $error("buffer drive does not follow gate");

endmodule

// *** verification/sia_initiator_model.sv ***
// Initiator model: answers each REQ with ACK and sends or captures one byte.
`timescale 1ns/1ps
module sia_initiator_model (
    input  wire logic       clk,
    input  wire logic       req_on,
    input  wire logic       drive_data,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_bad,
    input  wire logic [3:0] ack_dly,
    input  wire logic [7:0] db_wire,
    input  wire logic       dbp_wire,
    output logic            ack_n,
    output logic      [7:0] db_drive,
    output logic            dbp_drive,
    output logic            got_valid,
    output logic      [8:0] got
);
    // Released lines read high, as on a terminated bus.
    initial begin
        ack_n = 1'b1;
        db_drive = 8'hFF;
        dbp_drive = 1'b1;
        got_valid = 1'b0;
        got = 9'h000;
        forever begin
            @(posedge clk);
            if (req_on) begin
                if (drive_data) begin
                    db_drive <= ~tx_byte;
                    dbp_drive <= (^tx_byte) ^ tx_bad;
                end
                repeat (ack_dly) @(posedge clk);
                got <= {~dbp_wire, ~db_wire};
                got_valid <= !drive_data;
                ack_n <= 1'b0;
                @(posedge clk);
                got_valid <= 1'b0;
                while (req_on) @(posedge clk);
                ack_n <= 1'b1;
                db_drive <= 8'hFF;
                dbp_drive <= 1'b1;
            end
        end
    end
endmodule

// *** verification/sia_target_adapter_bench.sv ***
// Self-checking bench for the SCSI target bus adapter.
`timescale 1ns/1ps
module sia_target_adapter_bench
    import sia_pkg::*;
;
    logic        clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hF, ack_dly = 4'h2;
    logic [31:0] avs_writedata = READ_ZERO, avs_readdata;
    logic        avs_waitrequest, scsi_dbp_in, scsi_sel_in, scsi_busy_sense, scsi_ack_n;
    logic [7:0]  scsi_db_in, scsi_db_out, scsi_db_oe, buffer_data_bus_in = BYTE_ZERO;
    logic [7:0]  buffer_data_bus_out, tx_byte = BYTE_ZERO, m_db;
    logic        scsi_dbp_out, scsi_dbp_oe, scsi_sel_out, scsi_sel_oe, scsi_busy_drive_req;
    logic        scsi_bsy_oe, scsi_req_oe, scsi_msg_oe, scsi_cd_oe, scsi_io_oe;
    logic        buffer_data_bus_oe, port_b_ack, parity_or_error_out, busy_sense, sel_sense;
    logic        latch_out_strobe = 1'b0, bus_out_gate = 1'b0, bus_in_gate = 1'b0;
    logic        port_b_req = 1'b0, parity_mode_clear = 1'b1, target_drive_enable = 1'b1;
    logic        busy_drive_req = 1'b0, sel_drive_req = 1'b0, msg_phase_in = 1'b0;
    logic        cd_phase_in = 1'b0, io_phase_in = 1'b0, tx_bad = 1'b0, tb_sel = 1'b1;
    logic        tb_bsy = 1'b1, m_dbp, got_valid, perr = 1'b0;
    logic [8:0]  got;
    logic [63:0] rq[$];
    logic [8:0]  bq[$];
    int          errors = 0, check_count = 0, seed, n, i;

    always #2.5 clk = ~clk;
    // Open-collector lines: low wins among all drivers.
    assign scsi_db_in = (scsi_db_out | ~scsi_db_oe) & m_db;
    assign scsi_dbp_in = (scsi_dbp_out | ~scsi_dbp_oe) & m_dbp;
    assign scsi_sel_in = (scsi_sel_out | ~scsi_sel_oe) & tb_sel;
    assign scsi_busy_sense = (scsi_busy_drive_req | ~scsi_bsy_oe) & tb_bsy;

    sia_target_adapter dut_u (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .scsi_db_in,
        .scsi_db_out, .scsi_db_oe, .scsi_dbp_in, .scsi_dbp_out, .scsi_dbp_oe, .scsi_sel_in,
        .scsi_sel_out, .scsi_sel_oe, .scsi_busy_sense, .scsi_busy_drive_req, .scsi_bsy_oe, .scsi_ack_n,
        .scsi_req_oe, .scsi_msg_oe, .scsi_cd_oe, .scsi_io_oe, .buffer_data_bus_in,
        .buffer_data_bus_out, .buffer_data_bus_oe, .latch_out_strobe, .bus_out_gate,
        .bus_in_gate, .port_b_req, .port_b_ack, .parity_mode_clear, .parity_or_error_out,
        .target_drive_enable, .busy_drive_req, .busy_sense, .sel_drive_req, .sel_sense,
        .msg_phase_in, .cd_phase_in, .io_phase_in);

    sia_initiator_model init_u (.clk, .req_on(scsi_req_oe), .drive_data(~io_phase_in),
        .tx_byte, .tx_bad, .ack_dly, .db_wire(scsi_db_in), .dbp_wire(scsi_dbp_in),
        .ack_n(scsi_ack_n), .db_drive(m_db), .dbp_drive(m_dbp), .got_valid, .got);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Results are matched against the oldest note when they appear.
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && rq.size() > 0) begin
            cmp("readdata", rq[0][31:0], avs_readdata & rq[0][63:32]);
            void'(rq.pop_front());
        end
        if (got_valid === 1'b1 && bq.size() > 0)
            cmp("bus byte", {23'h0, bq.pop_front()}, {23'h0, got});
    end

    task automatic waitfor(ref logic s, input logic v);
        n = 0;
        while (s !== v) begin
            @(posedge clk);
            n++;
            if (n > 400) begin
                errors++;
                summarize();
            end
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        waitfor(avs_waitrequest, 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        rq.push_back({m, e & m});
        bus(1'b0, a, READ_ZERO, 4'hF);
    endtask

    task automatic xfer(input logic send, input logic bad, input logic [3:0] dly);
        logic [7:0] b;
        b = 8'($random(seed));
        tx_byte <= b;
        tx_bad <= bad;
        ack_dly <= dly;
        io_phase_in <= send;
        bus_in_gate <= !send;
        buffer_data_bus_in <= b;
        latch_out_strobe <= 1'b1;
        @(posedge clk);
        latch_out_strobe <= 1'b0;
        bus_out_gate <= send;
        port_b_req <= 1'b1;
        if (send)
            bq.push_back({~^b, b});
        waitfor(scsi_req_oe, 1'b1);
        if (send) begin
            cmp("data setup", 1, n >= DATA_SETUP_CYC + 2);
            cmp("data drive", 32'h0000_00FF, scsi_db_oe);
        end
        waitfor(port_b_ack, 1'b1);
        cmp("req released", 0, scsi_req_oe);
        @(posedge clk);
        if (!send) begin
            perr = perr | (parity_mode_clear & bad);
            cmp("buffer byte", b, buffer_data_bus_out);
            cmp("buffer drive", 1, buffer_data_bus_oe);
            cmp("parity out", parity_mode_clear ? perr : (~^b) ^ bad,
                parity_or_error_out);
        end
        port_b_req <= 1'b0;
        waitfor(port_b_ack, 1'b0);
        bus_out_gate <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 10;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(ADDR_CTRL, READ_ZERO, 32'hFFFF_FFFF);
        rd(4'h8, READ_ZERO, 32'hFFFF_FFFF);
        bus(1'b1, ADDR_CTRL, 32'h0000_0005, 4'h0);
        rd(ADDR_CTRL, READ_ZERO, 32'hFFFF_FFFF);
        bus(1'b1, ADDR_CTRL, 32'h0000_0002, 4'h1);
        rd(ADDR_CTRL, 32'h0000_0002, 32'hFFFF_FFFF);
        for (i = 0; i < 4; i++)
            xfer(1'b1, 1'b0, 4'(i * 3));
        xfer(1'b0, 1'b0, 4'h2);
        xfer(1'b0, 1'b1, 4'h6);
        xfer(1'b0, 1'b0, 4'h3);
        rd(ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
        parity_mode_clear <= 1'b0;
        perr = 1'b0;
        repeat (4) @(posedge clk);
        rd(ADDR_STATUS, READ_ZERO, 32'h0000_0001);
        xfer(1'b0, 1'b0, 4'h3);
        xfer(1'b0, 1'b1, 4'h4);
        parity_mode_clear <= 1'b1;
        tb_bsy <= 1'b0;
        repeat (4) @(posedge clk);
        cmp("busy sense", 1, busy_sense);
        tb_bsy <= 1'b1;
        tb_sel <= 1'b0;
        repeat (4) @(posedge clk);
        cmp("sel sense", 1, sel_sense);
        cmp("busy by sel", 1, busy_sense);
        tb_sel <= 1'b1;
        n = 0;
        repeat (8) begin
            @(posedge clk);
            n += (busy_sense === 1'b1);
        end
        cmp("bus free delay", 1, n >= BUS_FREE_MIN_CYC && n <= BUS_FREE_MAX_CYC);
        target_drive_enable <= 1'b0;
        sel_drive_req <= 1'b1;
        busy_drive_req <= 1'b1;
        msg_phase_in <= 1'b1;
        repeat (3) @(posedge clk);
        cmp("drivers off", 0, {scsi_sel_oe, scsi_msg_oe});
        cmp("busy drive", 1, scsi_bsy_oe);
        target_drive_enable <= 1'b1;
        repeat (3) @(posedge clk);
        cmp("sel drive", 3, {scsi_sel_oe, scsi_dbp_oe});
        sel_drive_req <= 1'b0;
        busy_drive_req <= 1'b0;
        for (i = 0; i < 8; i++) begin
            {msg_phase_in, cd_phase_in, io_phase_in} <= 3'(i);
            repeat (3) @(posedge clk);
            cmp("phase lines", i, {scsi_msg_oe, scsi_cd_oe, scsi_io_oe});
        end
        cmp("busy released", 0, scsi_bsy_oe);
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        summarize();
    end
endmodule
